//--- shared/hpir_pkg.sv
// constants for the host port interrupt routing block
package hpir_pkg;
    localparam logic [15:0] ADDR_BREAKPOINT = 16'h0140;
    localparam logic [15:0] ADDR_ROUTING = 16'h0142;
    localparam logic [15:0] ADDR_MSG1 = 16'h0144;
    localparam logic [15:0] ADDR_MSG2 = 16'h0148;
    localparam logic [15:0] ADDR_MAILBOX = 16'hc0c6;
    localparam logic [15:0] RESET_BREAKPOINT = 16'h0000;
    localparam logic [15:0] RESET_ROUTING = 16'h1400;
    localparam logic [15:0] RESET_MAILBOX = 16'h0000;
    localparam logic [15:0] ROUTING_WRITABLE = 16'hffcf;
    localparam logic [6:0] BREAKPOINT_VECTOR = 7'h7f;
    // routing bit positions
    localparam int BIT_BUS_POWER = 15;
    localparam int BIT_ID_PIN = 14;
    localparam int BIT_FRAME2_HOST = 13;
    localparam int BIT_FRAME2_CPU = 12;
    localparam int BIT_FRAME1_HOST = 11;
    localparam int BIT_FRAME1_CPU = 10;
    localparam int BIT_BUSRESET2 = 9;
    localparam int BIT_SWAP_HIGH = 8;
    localparam int BIT_WAKE2 = 7;
    localparam int BIT_WAKE1 = 6;
    localparam int BIT_DONE2 = 3;
    localparam int BIT_DONE1 = 2;
    localparam int BIT_BUSRESET1 = 1;
    localparam int BIT_SWAP_LOW = 0;
    // status word positions not shared with routing
    localparam int STAT_MAILBOX_IN = 8;
    localparam int STAT_MSG2 = 5;
    localparam int STAT_MSG1 = 4;
    localparam int STAT_MAILBOX_OUT = 0;
endpackage

//--- rtl/hpir_host_port_irq_routing.sv
// host port interrupt routing, breakpoint, doorbells and mailbox
`timescale 1ns/1ps
`default_nettype none
module hpir_host_port_irq_routing
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    // host parallel port, word access, native byte order internally
    input wire logic host_wr_in,
    input wire logic host_rd_in,
    input wire logic [15:0] host_addr_in,
    input wire logic [15:0] host_port_data_lines_in,
    output logic [15:0] host_port_data_lines_out,
    output logic host_port_data_lines_oe_n_out,
    input wire logic host_status_rd_in,
    output logic host_port_irq_pin_out,
    // on-chip cpu memory side
    input wire logic cpu_wr_in,
    input wire logic cpu_rd_in,
    input wire logic [15:0] cpu_addr_in,
    input wire logic [15:0] cpu_wdata_in,
    output logic [15:0] cpu_rdata_out,
    input wire logic [15:0] cpu_pc_in,
    output logic breakpoint_irq_out,
    output logic [6:0] breakpoint_vector_out,
    output logic mailbox_rx_full_out,
    output logic mailbox_tx_empty_out,
    // serial engine interrupt sources, already gated by engine enables
    input wire logic irq_bus_power_in,
    input wire logic irq_id_pin_in,
    input wire logic irq_frame2_in,
    input wire logic irq_frame1_in,
    input wire logic irq_busreset2_in,
    input wire logic irq_busreset1_in,
    input wire logic irq_wake2_in,
    input wire logic irq_wake1_in,
    input wire logic irq_done2_in,
    input wire logic irq_done1_in,
    output logic [15:0] cpu_irq_out
);
    // ****************************************
    // registers
    // ****************************************
    logic [15:0] breakpoint_addr;
    logic [15:0] routing;
    logic [15:0] mailbox;
    logic msg1_flag;
    logic msg2_flag;
    logic mbox_to_host;
    logic mbox_from_host;
    logic bp_pending;
    logic [15:0] host_wdata;
    logic [15:0] host_rdata;
    logic [15:0] status_word;
    logic [15:0] host_src;
    logic swap;

    // host keeps both bits equal; only the high one is consulted
    assign swap = routing[hpir_pkg::BIT_SWAP_HIGH];

    // exchange byte lanes when swap is on
    assign host_wdata = swap ? {host_port_data_lines_in[7:0],
        host_port_data_lines_in[15:8]} : host_port_data_lines_in;

    // host port writes breakpoint, cpu has no write path
    // behaves as the cpu's own breakpoint register
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            breakpoint_addr <= hpir_pkg::RESET_BREAKPOINT;
        else if (host_wr_in && host_addr_in == hpir_pkg::ADDR_BREAKPOINT)
            breakpoint_addr <= host_wdata;
    end

    // pc match raises vector 127; a zero write clears
    // clear relies on the host writing zero to the breakpoint
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            bp_pending <= 1'b0;
        else if (breakpoint_addr != 16'h0000 && cpu_pc_in == breakpoint_addr)
            bp_pending <= 1'b1;
        else if (host_wr_in && host_addr_in == hpir_pkg::ADDR_BREAKPOINT &&
                 host_wdata == 16'h0000)
            bp_pending <= 1'b0;
    end
    assign breakpoint_irq_out = bp_pending;
    assign breakpoint_vector_out = hpir_pkg::BREAKPOINT_VECTOR;

    // routing written only from the host port
    // reserved bits 5 and 4 held at zero
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            routing <= hpir_pkg::RESET_ROUTING;
        else if (host_wr_in && host_addr_in == hpir_pkg::ADDR_ROUTING)
            routing <= host_wdata & hpir_pkg::ROUTING_WRITABLE;
    end

    // cpu write sets doorbell flag, host read clears; set wins
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            msg1_flag <= 1'b0;
            msg2_flag <= 1'b0;
        end
        else
        begin
            if (cpu_wr_in && cpu_addr_in == hpir_pkg::ADDR_MSG1)
                msg1_flag <= 1'b1;
            else if (host_rd_in && host_addr_in == hpir_pkg::ADDR_MSG1)
                msg1_flag <= 1'b0;
            if (cpu_wr_in && cpu_addr_in == hpir_pkg::ADDR_MSG2)
                msg2_flag <= 1'b1;
            else if (host_rd_in && host_addr_in == hpir_pkg::ADDR_MSG2)
                msg2_flag <= 1'b0;
        end
    end

    // mailbox data: either side may write; a same-cycle clash favours cpu
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mailbox <= hpir_pkg::RESET_MAILBOX;
        else if (cpu_wr_in && cpu_addr_in == hpir_pkg::ADDR_MAILBOX)
            mailbox <= cpu_wdata_in;
        else if (host_wr_in && host_addr_in == hpir_pkg::ADDR_MAILBOX)
            mailbox <= host_wdata;
    end

    // cpu write raises host pin until the host reads; set wins
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mbox_to_host <= 1'b0;
        else if (cpu_wr_in && cpu_addr_in == hpir_pkg::ADDR_MAILBOX)
            mbox_to_host <= 1'b1;
        else if (host_rd_in && host_addr_in == hpir_pkg::ADDR_MAILBOX)
            mbox_to_host <= 1'b0;
    end

    // incoming message flag, cleared by the cpu reading the mailbox
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            mbox_from_host <= 1'b0;
        else if (host_wr_in && host_addr_in == hpir_pkg::ADDR_MAILBOX)
            mbox_from_host <= 1'b1;
        else if (cpu_rd_in && cpu_addr_in == hpir_pkg::ADDR_MAILBOX)
            mbox_from_host <= 1'b0;
    end
    assign mailbox_rx_full_out = mbox_from_host;
    // tx empty means the host has drained what the cpu wrote
    assign mailbox_tx_empty_out = ~mbox_to_host;

    // ****************************************
    // steering
    // ****************************************
    // sources arrive enabled; routing picks where they go, and drops a frame source with both its bits clear
    always_comb
    begin
        host_src = 16'h0000;
        cpu_irq_out = 16'h0000;
        host_src[15] = irq_bus_power_in & routing[hpir_pkg::BIT_BUS_POWER];
        cpu_irq_out[15] = irq_bus_power_in & ~routing[hpir_pkg::BIT_BUS_POWER];
        host_src[14] = irq_id_pin_in & routing[hpir_pkg::BIT_ID_PIN];
        cpu_irq_out[14] = irq_id_pin_in & ~routing[hpir_pkg::BIT_ID_PIN];
        // engine 2 frame, independent bits, both may be on
        // double routing leaves clearing to firmware
        host_src[12] = irq_frame2_in & routing[hpir_pkg::BIT_FRAME2_HOST];
        cpu_irq_out[12] = irq_frame2_in & routing[hpir_pkg::BIT_FRAME2_CPU];
        host_src[10] = irq_frame1_in & routing[hpir_pkg::BIT_FRAME1_HOST];
        cpu_irq_out[10] = irq_frame1_in & routing[hpir_pkg::BIT_FRAME1_CPU];
        host_src[9] = irq_busreset2_in & routing[hpir_pkg::BIT_BUSRESET2];
        cpu_irq_out[9] = irq_busreset2_in & ~routing[hpir_pkg::BIT_BUSRESET2];
        host_src[1] = irq_busreset1_in & routing[hpir_pkg::BIT_BUSRESET1];
        cpu_irq_out[1] = irq_busreset1_in & ~routing[hpir_pkg::BIT_BUSRESET1];
        host_src[7] = irq_wake2_in & routing[hpir_pkg::BIT_WAKE2];
        cpu_irq_out[7] = irq_wake2_in & ~routing[hpir_pkg::BIT_WAKE2];
        host_src[6] = irq_wake1_in & routing[hpir_pkg::BIT_WAKE1];
        cpu_irq_out[6] = irq_wake1_in & ~routing[hpir_pkg::BIT_WAKE1];
        host_src[3] = irq_done2_in & routing[hpir_pkg::BIT_DONE2];
        cpu_irq_out[3] = irq_done2_in & ~routing[hpir_pkg::BIT_DONE2];
        host_src[2] = irq_done1_in & routing[hpir_pkg::BIT_DONE1];
        cpu_irq_out[2] = irq_done1_in & ~routing[hpir_pkg::BIT_DONE1];
    end

    always_comb
    begin
        status_word = host_src;
        status_word[hpir_pkg::STAT_MAILBOX_IN] = mbox_from_host;
        status_word[hpir_pkg::STAT_MSG2] = msg2_flag;
        status_word[hpir_pkg::STAT_MSG1] = msg1_flag;
        status_word[hpir_pkg::STAT_MAILBOX_OUT] = mbox_to_host;
    end

    // pin is the or of host-routed sources and host-bound flags
    assign host_port_irq_pin_out = (|host_src) | msg1_flag | msg2_flag |
        mbox_to_host;

    // ****************************************
    // read paths
    // ****************************************
    // host port decode of the three registers plus status
    always_comb
    begin
        host_rdata = 16'h0000;
        if (host_status_rd_in)
            host_rdata = status_word;
        else
            unique case (host_addr_in)
                hpir_pkg::ADDR_BREAKPOINT: host_rdata = breakpoint_addr;
                hpir_pkg::ADDR_ROUTING: host_rdata = routing;
                hpir_pkg::ADDR_MAILBOX: host_rdata = mailbox;
                default: host_rdata = 16'h0000;
            endcase
    end

    // read data registered; lanes swapped on the way out when swap is on
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            host_port_data_lines_out <= 16'h0000;
        else if (host_rd_in || host_status_rd_in)
            host_port_data_lines_out <= swap ? {host_rdata[7:0],
                host_rdata[15:8]} : host_rdata;
    end

    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            host_port_data_lines_oe_n_out <= 1'b1;
        else
            host_port_data_lines_oe_n_out <= ~(host_rd_in | host_status_rd_in);
    end

    // cpu sees breakpoint and routing read-only
    always_ff @(posedge clk_sys_in or posedge rst_in)
    begin
        if (rst_in)
            cpu_rdata_out <= 16'h0000;
        else if (cpu_rd_in)
            unique case (cpu_addr_in)
                hpir_pkg::ADDR_BREAKPOINT: cpu_rdata_out <= breakpoint_addr;
                hpir_pkg::ADDR_ROUTING: cpu_rdata_out <= routing;
                hpir_pkg::ADDR_MAILBOX: cpu_rdata_out <= mailbox;
                default: cpu_rdata_out <= 16'h0000;
            endcase
    end

    // ****************************************
    // checks
    // ****************************************
    sequence s_cpu_msg1;
        cpu_wr_in && cpu_addr_in == hpir_pkg::ADDR_MSG1;
    endsequence
    sequence s_cpu_msg2;
        cpu_wr_in && cpu_addr_in == hpir_pkg::ADDR_MSG2;
    endsequence
    sequence s_cpu_mbox;
        cpu_wr_in && cpu_addr_in == hpir_pkg::ADDR_MAILBOX;
    endsequence
    sequence s_pc_hit;
        breakpoint_addr != 16'h0000 && cpu_pc_in == breakpoint_addr;
    endsequence
    // zero written by the host while the pc is not on the old address
    sequence s_host_bp_zero;
        host_wr_in && host_addr_in == hpir_pkg::ADDR_BREAKPOINT &&
        host_wdata == 16'h0000 && cpu_pc_in != breakpoint_addr;
    endsequence

    a_bp_match_raise: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) s_pc_hit |=> bp_pending)
        else $error("breakpoint match not raised");
    a_bp_zero_clear: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) s_host_bp_zero |=> !bp_pending)
        else $error("breakpoint not cleared by zero");
    a_cpu_no_route_write: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) !(host_wr_in && host_addr_in ==
        hpir_pkg::ADDR_ROUTING) |=> $stable(routing))
        else $error("routing changed without host write");
    a_route_reserved_zero: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) routing[5:4] == 2'b00)
        else $error("reserved routing bits set");
    a_bus_power_steer: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) irq_bus_power_in |->
        (cpu_irq_out[15] != routing[hpir_pkg::BIT_BUS_POWER]))
        else $error("bus power misrouted");
    a_frame2_both: assert property (@(posedge clk_sys_in)
        disable iff (rst_in)
        (irq_frame2_in && routing[13] && routing[12]) |->
        (cpu_irq_out[12] && host_port_irq_pin_out))
        else $error("frame2 not sent to both");
    a_frame1_cpu_bit: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) irq_frame1_in |->
        (cpu_irq_out[10] == routing[hpir_pkg::BIT_FRAME1_CPU]))
        else $error("frame1 cpu routing wrong");
    a_msg1_flag_pin: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) s_cpu_msg1 |=> (msg1_flag && host_port_irq_pin_out))
        else $error("doorbell 1 flag not raised");
    a_msg2_flag_pin: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) s_cpu_msg2 |=> (msg2_flag && host_port_irq_pin_out))
        else $error("doorbell 2 flag not raised");
    a_mbox_cpu_raise: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) s_cpu_mbox |=> (mbox_to_host && host_port_irq_pin_out))
        else $error("mailbox pin not raised");
    a_mbox_host_clear: assert property (@(posedge clk_sys_in)
        disable iff (rst_in) (host_rd_in && host_addr_in ==
        hpir_pkg::ADDR_MAILBOX && !(cpu_wr_in && cpu_addr_in ==
        hpir_pkg::ADDR_MAILBOX)) |=> !mbox_to_host)
        else $error("mailbox pin not released");
endmodule
`default_nettype wire

//--- bench/hpir_host_model.sv
// external host processor model on the parallel host port
`timescale 1ns/1ps
`default_nettype none
module hpir_host_model
(
    input wire logic clk_in,
    input wire logic [15:0] q_in,
    input wire logic oe_n_in,
    output logic wr_out,
    output logic rd_out,
    output logic st_out,
    output logic [15:0] a_out,
    output logic [15:0] d_out
);
    logic swap = 1'b0;
    initial
    begin
        {wr_out, rd_out, st_out, a_out, d_out} = {3'h0, 16'h0, 16'hffff};
    end
    // op 0 write, 1 read, 2 status read; q carries the pins as seen
    task automatic go(input int op, input logic [15:0] a, d,
        output logic [15:0] q);
        @(posedge clk_in);
        {wr_out, rd_out, st_out, a_out} <= {op == 0, op == 1, op == 2, a};
        d_out <= op != 0 ? ~d_out : swap ? {d[7:0], d[15:8]} : d;
        @(posedge clk_in);
        // nothing holds idle lines, so show the inverse
        {wr_out, rd_out, st_out, a_out, d_out} <= {3'h0, ~a, ~d_out};
        if (op == 0 && a == hpir_pkg::ADDR_ROUTING)
            swap = d[8] & d[0];
        #1 q = oe_n_in ? 16'hxxxx : q_in;
    endtask
endmodule
`default_nettype wire

//--- bench/hpir_host_port_irq_routing_bench.sv
// self-checking bench for the host port interrupt routing block
`timescale 1ns/1ps
`default_nettype none
module hpir_host_port_irq_routing_bench;
    localparam int hb[10] = '{15, 14, 13, 11, 9, 7, 6, 3, 2, 1};
    localparam int cp[10] = '{15, 14, 12, 10, 9, 7, 6, 3, 2, 1};
    logic clk = 1'b0, rst = 1'b1, cw = 1'b0, cr = 1'b0;
    logic [15:0] ca = 16'h0, cd = 16'h0, pc = 16'h0;
    logic [9:0] src = 10'h0;
    logic hw, hr, hs, oe_n, pin, bp, rxf, txe;
    logic [15:0] ha, hd, hq, crq, irq, q, r, e;
    logic [6:0] vec;
    int err_total = 0, samples_checked = 0;
    hpir_host_port_irq_routing dut_u
    (
        .clk_sys_in(clk), .rst_in(rst), .host_wr_in(hw), .host_rd_in(hr),
        .host_addr_in(ha), .host_port_data_lines_in(hd),
        .host_port_data_lines_out(hq), .host_port_data_lines_oe_n_out(oe_n),
        .host_status_rd_in(hs), .host_port_irq_pin_out(pin), .cpu_wr_in(cw),
        .cpu_rd_in(cr), .cpu_addr_in(ca), .cpu_wdata_in(cd), .cpu_pc_in(pc),
        .cpu_rdata_out(crq), .breakpoint_irq_out(bp), .cpu_irq_out(irq),
        .breakpoint_vector_out(vec), .mailbox_rx_full_out(rxf),
        .mailbox_tx_empty_out(txe), .irq_bus_power_in(src[0]),
        .irq_id_pin_in(src[1]), .irq_frame2_in(src[2]),
        .irq_frame1_in(src[3]), .irq_busreset2_in(src[4]),
        .irq_wake2_in(src[5]), .irq_wake1_in(src[6]),
        .irq_done2_in(src[7]), .irq_done1_in(src[8]),
        .irq_busreset1_in(src[9])
    );
    hpir_host_model host_u
    (
        .clk_in(clk), .q_in(hq), .oe_n_in(oe_n), .wr_out(hw), .rd_out(hr),
        .st_out(hs), .a_out(ha), .d_out(hd)
    );
    task automatic chk(input string nm, input logic [15:0] s, x);
        samples_checked++;
        if (s !== x)
        begin
            err_total++;
            $display("unexpected %s expected %h seen %h", nm, x, s);
        end
    endtask
    task automatic close_out(input int hung);
        err_total += hung;
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic cpu(input logic w, input logic [15:0] a, d);
        @(posedge clk);
        {cw, cr, ca, cd} <= {w, ~w, a, d};
        @(posedge clk);
        {cw, cr} <= 2'h0;
        #1 q = crq;
    endtask
    initial forever #2.5 clk = ~clk;
    // far beyond the few hundred cycles the sequence needs
    initial #100000 close_out(1);
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        host_u.go(1, 16'h0142, 16'h0, q);
        chk("routing reset", q, 16'h1400);
        cpu(1'b1, 16'h0142, 16'h0);
        cpu(1'b1, 16'h0140, 16'h1234);
        cpu(1'b0, 16'h0142, 16'h0);
        chk("cpu routing", q, 16'h1400);
        host_u.go(1, 16'h0140, 16'h0, q);
        chk("breakpoint", q, 16'h0);
        host_u.go(1, 16'h0150, 16'h0, q);
        chk("unmapped", q, 16'h0);
        host_u.go(0, 16'h0142, 16'hfefe, q);
        host_u.go(1, 16'h0142, 16'h0, q);
        chk("reserved", q, 16'hfece);
        for (int i = 0; i < 10; i++)
            for (int k = 0; k < 3; k++)
            begin
                r = 16'h0;
                r[hb[i]] = k > 0;
                r[cp[i]] = r[cp[i]] | (k == 2);
                host_u.go(0, 16'h0142, r, q);
                @(posedge clk) src <= 10'h001 << i;
                @(posedge clk);
                #1 e = 16'h0;
                e[cp[i]] = hb[i] != cp[i] ? r[cp[i]] : ~r[hb[i]];
                chk("cpu irq", irq, e);
                chk("pin", {15'h0, pin}, {15'h0, r[hb[i]]});
                host_u.go(2, 16'h0, 16'h0, q);
                e = {15'h0, r[hb[i]]} << cp[i];
                chk("status", q, e);
                @(posedge clk) src <= 10'h0;
            end
        for (int m = 0; m < 2; m++)
        begin
            cpu(1'b1, m ? 16'h0148 : 16'h0144, 16'h5a5a);
            chk("msg pin", {15'h0, pin}, 16'h0001);
            host_u.go(2, 16'h0, 16'h0, q);
            chk("msg flag", q, 16'h0010 << m);
            host_u.go(1, m ? 16'h0148 : 16'h0144, 16'h0, q);
            chk("msg clear", {15'h0, pin}, 16'h0);
        end
        cpu(1'b1, 16'hc0c6, 16'ha1b2);
        chk("mbox pin txe", {14'h0, pin, txe}, 16'h0002);
        host_u.go(2, 16'h0, 16'h0, q);
        chk("mbox out flag", q, 16'h0001);
        host_u.go(1, 16'hc0c6, 16'h0, q);
        chk("mbox read", q, 16'ha1b2);
        chk("mbox pin txe", {14'h0, pin, txe}, 16'h0001);
        host_u.go(0, 16'hc0c6, 16'h3c4d, q);
        chk("rx full", {15'h0, rxf}, 16'h0001);
        host_u.go(2, 16'h0, 16'h0, q);
        chk("mbox in flag", q, 16'h0100);
        cpu(1'b0, 16'hc0c6, 16'h0);
        chk("cpu mbox rx full", {q[15:1], rxf}, 16'h3c4c);
        host_u.go(0, 16'h0140, 16'h0abc, q);
        cpu(1'b0, 16'h0140, 16'h0);
        chk("cpu breakpoint", q, 16'h0abc);
        @(posedge clk) pc <= 16'h0abc;
        @(posedge clk) pc <= 16'h0100;
        #1 chk("match vector", {bp, vec}, 16'h00ff);
        repeat (3) @(posedge clk);
        #1 chk("held", {15'h0, bp}, 16'h0001);
        host_u.go(0, 16'h0140, 16'h0, q);
        @(posedge clk);
        #1 chk("cleared", {15'h0, bp}, 16'h0);
        host_u.go(0, 16'h0142, 16'h2d05, q);
        host_u.go(1, 16'h0142, 16'h0, q);
        chk("swapped routing", q, 16'h052d);
        host_u.go(0, 16'hc0c6, 16'h1234, q);
        cpu(1'b0, 16'hc0c6, 16'h0);
        chk("swapped write", q, 16'h1234);
        cpu(1'b1, 16'hc0c6, 16'h5678);
        host_u.go(1, 16'hc0c6, 16'h0, q);
        chk("swapped read", q, 16'h7856);
        close_out(0);
    end
endmodule
`default_nettype wire
